/* rtl/hsp_defines.svh */
// Register offsets, control codes and timing counts for the switch controller.
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH
`define HSP_CLK_MHZ 100
`define HSP_OC_FILTER_US 16
`define HSP_OL_FILTER_US 64
`define HSP_OC_FILTER_CYC (`HSP_OC_FILTER_US * `HSP_CLK_MHZ)
`define HSP_OL_FILTER_CYC (`HSP_OL_FILTER_US * `HSP_CLK_MHZ)
`define HSP_PWM_FAST_HZ 400
`define HSP_PWM_SLOW_HZ 200
`define HSP_TICK_FAST_CYC ((`HSP_CLK_MHZ * 1000000) / (`HSP_PWM_FAST_HZ * 256))
`define HSP_TICK_SLOW_CYC ((`HSP_CLK_MHZ * 1000000) / (`HSP_PWM_SLOW_HZ * 256))
`define HSP_ADR_CTRL_LO 4'h0
`define HSP_ADR_CTRL_HI 4'h1
`define HSP_ADR_DUTY1 4'h2
`define HSP_ADR_DUTY2 4'h3
`define HSP_ADR_FREQ 4'h4
`define HSP_ADR_REC 4'h5
`define HSP_ADR_OC_STAT 4'h6
`define HSP_ADR_OL_STAT 4'h7
`define HSP_ADR_SUP_STAT 4'h8
`define HSP_CODE_OFF 3'h0
`define HSP_CODE_ON 3'h1
`define HSP_CODE_TMR1 3'h2
`define HSP_CODE_TMR2 3'h3
`define HSP_CODE_PWM1 3'h4
`define HSP_CODE_PWM2 3'h5
`endif

/* rtl/hsp_pkg.sv */
// Types shared by the switch controller.
package hsp_pkg;
  typedef enum logic [2:0] {
    HSP_MODE_NORMAL,
    HSP_MODE_STOP,
    HSP_MODE_SLEEP,
    HSP_MODE_RESTART,
    HSP_MODE_FAILSAFE
  } hsp_mode_e;
  typedef struct packed {
    logic [3:0] over_current;
    logic [3:0] open_load;
    logic supply_over;
    logic supply_under;
  } hsp_sense_s;
endpackage

/* rtl/hsp_switch_ctrl.sv */
// Four high-side switch controller with two PWM generators and a Wishbone register port.
`timescale 1ns/1ps
`include "hsp_defines.svh"
module hsp_switch_ctrl #(
  parameter int OC_FILTER_CYC = `HSP_OC_FILTER_CYC,
  parameter int OL_FILTER_CYC = `HSP_OL_FILTER_CYC,
  parameter int TICK_FAST_CYC = `HSP_TICK_FAST_CYC,
  parameter int TICK_SLOW_CYC = `HSP_TICK_SLOW_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device mode, analog sense and timers
  input wire hsp_pkg::hsp_mode_e device_mode,
  input wire hsp_pkg::hsp_sense_s sense,
  input wire logic timer_one,
  input wire logic timer_two,
  // Switch drive
  output logic [3:0] high_side_output
);
  // The filter and prescaler counters are 24 bits wide; larger counts would wrap.
  if (OC_FILTER_CYC < 1 || OC_FILTER_CYC > 32'hffffff ||
      OL_FILTER_CYC < 1 || OL_FILTER_CYC > 32'hffffff) begin : gen_bad_filter
    $error("hsp_switch_ctrl: filter counts must fit the 24-bit counters");
  end
  if (TICK_FAST_CYC < 1 || TICK_FAST_CYC > 32'hffffff ||
      TICK_SLOW_CYC < 1 || TICK_SLOW_CYC > 32'hffffff) begin : gen_bad_tick
    $error("hsp_switch_ctrl: prescaler counts must fit the 24-bit counters");
  end

  logic [2:0] code_reg [4];
  logic [7:0] pwm_one_duty_setting, pwm_two_duty_setting;
  logic [1:0] pwm_frequency_select;
  logic supply_fault_recovery_enable;
  logic [3:0] overcurrent_status_group, open_load_status_group;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic supply_fault_reg;
  logic [7:0] phase_reg [2];
  logic [23:0] tick_reg [2];
  logic [1:0] pwm_level;
  logic [23:0] oc_cnt_reg [4];
  logic [23:0] ol_cnt_reg [4];

  wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  // A write lands on the edge that samples the acknowledge, so it happens exactly once.
  wire bus_wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire supply_fault = sense.supply_over || sense.supply_under;
  wire supply_clear = supply_fault_reg && !supply_fault;
  // Outputs are dead while the device resets or sits in fail-safe.
  wire mode_block = (device_mode == hsp_pkg::HSP_MODE_RESTART) ||
    (device_mode == hsp_pkg::HSP_MODE_FAILSAFE);
  // Configuration is frozen outside normal mode; stop and sleep keep what was set.
  wire cfg_open = device_mode == hsp_pkg::HSP_MODE_NORMAL;
  logic [3:0] oc_trip;
  logic [3:0] ol_trip;

  // PWM generators: a prescaler tick advances an 8-bit phase, so a period is 256 ticks.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_pwm
      wire [23:0] tick_max = pwm_frequency_select[g] ?
        24'(TICK_FAST_CYC - 1) : 24'(TICK_SLOW_CYC - 1);
      wire [7:0] duty = (g == 0) ? pwm_one_duty_setting : pwm_two_duty_setting;
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          tick_reg[g] <= 24'h0;
          phase_reg[g] <= 8'h0;
        end else if (clk_en) begin
          if (tick_reg[g] >= tick_max) begin
            tick_reg[g] <= 24'h0;
            phase_reg[g] <= phase_reg[g] + 8'h1;
          end else begin
            tick_reg[g] <= tick_reg[g] + 24'h1;
          end
        end
      end
      // Duty 1 gives one tick of on-time; the switch edges are slower, so it will not show.
      assign pwm_level[g] = phase_reg[g] < duty;
    end
  endgenerate

  // Per-switch routing and fault filters.
  genvar s;
  generate
    for (s = 0; s < 4; s++) begin : gen_sw
      logic drive;
      always_comb begin
        case (code_reg[s])
          `HSP_CODE_ON: drive = 1'b1;
          `HSP_CODE_TMR1: drive = timer_one;
          `HSP_CODE_TMR2: drive = timer_two;
          `HSP_CODE_PWM1: drive = pwm_level[0];
          `HSP_CODE_PWM2: drive = pwm_level[1];
          default: drive = 1'b0;
        endcase
      end
      // Stop and sleep do not gate the drive, so cyclic sense and PWM go on.
      wire on_now = drive && !mode_block && !supply_fault;
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          high_side_output[s] <= 1'b0;
          oc_cnt_reg[s] <= 24'h0;
          ol_cnt_reg[s] <= 24'h0;
        end else if (clk_en) begin
          high_side_output[s] <= on_now && !oc_trip[s];
          // Filters run in normal, stop and sleep; restart and fail-safe force the output off, so they stay at zero.
          if (high_side_output[s] && sense.over_current[s]) begin
            oc_cnt_reg[s] <= oc_trip[s] ? oc_cnt_reg[s] : oc_cnt_reg[s] + 24'h1;
          end else begin
            oc_cnt_reg[s] <= 24'h0;
          end
          if (high_side_output[s] && sense.open_load[s]) begin
            ol_cnt_reg[s] <= ol_trip[s] ? ol_cnt_reg[s] : ol_cnt_reg[s] + 24'h1;
          end else begin
            ol_cnt_reg[s] <= 24'h0;
          end
        end
      end
      assign oc_trip[s] = oc_cnt_reg[s] >= 24'(OC_FILTER_CYC);
      assign ol_trip[s] = ol_cnt_reg[s] >= 24'(OL_FILTER_CYC);

      // Control code: over-current and unrecovered supply faults clear it; clear beats a write.
      wire [2:0] wr_code = wb_dat_i[3*(s%2) +: 3];
      wire wr_hit = bus_wr && cfg_open &&
        (wb_adr_i == ((s < 2) ? `HSP_ADR_CTRL_LO : `HSP_ADR_CTRL_HI));
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          code_reg[s] <= `HSP_CODE_OFF;
          overcurrent_status_group[s] <= 1'b0;
          open_load_status_group[s] <= 1'b0;
        end else if (clk_en) begin
          if (oc_trip[s]) begin
            code_reg[s] <= `HSP_CODE_OFF;
          end else if (supply_clear && !supply_fault_recovery_enable) begin
            code_reg[s] <= `HSP_CODE_OFF;
          end else if (wr_hit) begin
            code_reg[s] <= wr_code;
          end
          // Sticky flags: writing one clears, a new event in the same cycle wins.
          if (oc_trip[s]) begin
            overcurrent_status_group[s] <= 1'b1;
          end else if (bus_wr && wb_adr_i == `HSP_ADR_OC_STAT && wb_dat_i[s]) begin
            overcurrent_status_group[s] <= 1'b0;
          end
          if (ol_trip[s]) begin
            open_load_status_group[s] <= 1'b1;
          end else if (bus_wr && wb_adr_i == `HSP_ADR_OL_STAT && wb_dat_i[s]) begin
            open_load_status_group[s] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Remaining configuration registers, writable only in normal mode.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pwm_one_duty_setting <= 8'h0;
      pwm_two_duty_setting <= 8'h0;
      pwm_frequency_select <= 2'h0;
      supply_fault_recovery_enable <= 1'b0;
      supply_fault_reg <= 1'b0;
    end else if (clk_en) begin
      supply_fault_reg <= supply_fault;
      if (bus_wr && cfg_open) begin
        if (wb_adr_i == `HSP_ADR_DUTY1) pwm_one_duty_setting <= wb_dat_i[7:0];
        if (wb_adr_i == `HSP_ADR_DUTY2) pwm_two_duty_setting <= wb_dat_i[7:0];
        if (wb_adr_i == `HSP_ADR_FREQ) pwm_frequency_select <= wb_dat_i[1:0];
        if (wb_adr_i == `HSP_ADR_REC) supply_fault_recovery_enable <= wb_dat_i[0];
      end
    end
  end

  // Read mux; unmapped addresses read zero and still acknowledge.
  logic [31:0] rmux;
  always_comb begin
    case (wb_adr_i)
      `HSP_ADR_CTRL_LO: rmux = {26'h0, code_reg[1], code_reg[0]};
      `HSP_ADR_CTRL_HI: rmux = {26'h0, code_reg[3], code_reg[2]};
      `HSP_ADR_DUTY1: rmux = {24'h0, pwm_one_duty_setting};
      `HSP_ADR_DUTY2: rmux = {24'h0, pwm_two_duty_setting};
      `HSP_ADR_FREQ: rmux = {30'h0, pwm_frequency_select};
      `HSP_ADR_REC: rmux = {31'h0, supply_fault_recovery_enable};
      `HSP_ADR_OC_STAT: rmux = {28'h0, overcurrent_status_group};
      `HSP_ADR_OL_STAT: rmux = {28'h0, open_load_status_group};
      `HSP_ADR_SUP_STAT: rmux = {30'h0, sense.supply_under, sense.supply_over};
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else if (clk_en) begin
      ack_reg <= bus_req;
      if (bus_req) rdat_reg <= rmux;
    end
  end
  // A low clock enable hides the acknowledge, so no master completes on an edge that writes nothing.
  assign wb_ack_o = ack_reg && wb_cyc_i && wb_stb_i && clk_en;
  assign wb_dat_o = rdat_reg;

  // Assertions.
  property p_mode_off;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && mode_block |=> high_side_output == 4'h0;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("output on in restart or fail-safe");

  property p_oc_clear;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && oc_trip[0] |=> code_reg[0] == `HSP_CODE_OFF && overcurrent_status_group[0];
  endproperty
  a_oc_clear: assert property (p_oc_clear) else $error("over-current did not clear switch");

  property p_oc_filter;
    @(posedge ref_clk) disable iff (!rstn)
      $rose(oc_cnt_reg[0] == 24'h1) |-> !oc_trip[0];
  endproperty
  a_oc_filter: assert property (p_oc_filter) else $error("over-current tripped too early");

  property p_ol_keep;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && ol_trip[1] && !oc_trip[1] && !mode_block && !supply_fault &&
      code_reg[1] == `HSP_CODE_ON |=> open_load_status_group[1] && high_side_output[1];
  endproperty
  a_ol_keep: assert property (p_ol_keep) else $error("open load handled wrongly");

  property p_supply_off;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && supply_fault |=> high_side_output == 4'h0;
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("output on during supply fault");

  property p_no_rec;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && supply_clear && !supply_fault_recovery_enable |=> code_reg[2] == `HSP_CODE_OFF;
  endproperty
  a_no_rec: assert property (p_no_rec) else $error("control kept without recovery");

  property p_pwm_follow;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && code_reg[0] == `HSP_CODE_PWM1 && !mode_block && !supply_fault && !oc_trip[0]
      |=> high_side_output[0] == $past(pwm_level[0]);
  endproperty
  a_pwm_follow: assert property (p_pwm_follow) else $error("PWM not on output");

  property p_duty_zero;
    @(posedge ref_clk) disable iff (!rstn)
      pwm_two_duty_setting == 8'h0 |-> !pwm_level[1];
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("PWM high at zero duty");

  property p_lowpower_on;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && device_mode == hsp_pkg::HSP_MODE_SLEEP && code_reg[0] == `HSP_CODE_ON &&
      !supply_fault && !oc_trip[0] |=> high_side_output[0];
  endproperty
  a_lowpower_on: assert property (p_lowpower_on) else $error("switch dropped in sleep");

  property p_cfg_locked;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && bus_wr && !cfg_open && wb_adr_i == `HSP_ADR_CTRL_LO && !oc_trip[0] &&
      !supply_clear |=> $stable(code_reg[0]);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("locked control changed");

  property p_oc_hold;
    @(posedge ref_clk) disable iff (!rstn)
      clk_en && code_reg[0] == `HSP_CODE_OFF && !gen_sw[0].wr_hit
      |=> code_reg[0] == `HSP_CODE_OFF;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("switched-off output came back");
endmodule

/* sim/hsp_switch_ctrl_tb.sv */
// Self-checking testbench for the four-switch controller.
`timescale 1ns/1ps
module hsp_switch_ctrl_tb;
  typedef struct packed {
    logic [3:0] adr;
    logic [7:0] dat;
    logic t1;
    logic t2;
    logic [3:0] out;
  } hsp_row_s;
  logic ref_clk, rstn, en, cyc, stb, we, t1, t2;
  logic [3:0] adr;
  logic [31:0] wdat, rdat;
  wire [31:0] dat_o;
  wire ack;
  wire [3:0] hso;
  wire [31:0] hso32 = {28'h0, hso};
  hsp_pkg::hsp_mode_e mode;
  hsp_pkg::hsp_sense_s sense;
  int n_mismatch, total_checks, cycles, hi1, hi2;
  // Direct codes and timer routing, one write per row.
  hsp_row_s rows [6] = '{
    '{4'h0, 8'h01, 1'b0, 1'b0, 4'h1}, '{4'h0, 8'h09, 1'b0, 1'b0, 4'h3},
    '{4'h1, 8'h1a, 1'b1, 1'b0, 4'h7}, '{4'h1, 8'h1a, 1'b0, 1'b1, 4'hb},
    '{4'h0, 8'h3f, 1'b0, 1'b1, 4'h8}, '{4'h1, 8'h00, 1'b0, 1'b1, 4'h0}};

  // Short filters and ticks keep the slow PWM period at 1024 cycles and the fast one at 512.
  hsp_switch_ctrl #(.OC_FILTER_CYC(8), .OL_FILTER_CYC(16), .TICK_FAST_CYC(2),
      .TICK_SLOW_CYC(4)) hsp_switch_ctrl_inst (
    .ref_clk(ref_clk), .rstn(rstn), .clk_en(en), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .device_mode(mode), .sense(sense), .timer_one(t1), .timer_two(t2),
    .high_side_output(hso));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; holds the request until ack is sampled.
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk);
  endtask

  task idle(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  initial begin
    rstn = 1'b0;
    en = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    t1 = 1'b0;
    t2 = 1'b0;
    mode = hsp_pkg::HSP_MODE_NORMAL;
    sense = '0;
    n_mismatch = 0;
    total_checks = 0;
    cycles = 0;
    idle(6);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check(hso32, 32'h0);
    wb(1'b0, 4'h0, 32'h0);
    check(rdat, 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    check(rdat, 32'h0);
    wb(1'b0, 4'hf, 32'h0);
    check(rdat, 32'h0);
    foreach (rows[i]) begin
      t1 <= rows[i].t1;
      t2 <= rows[i].t2;
      wb(1'b1, rows[i].adr, {24'h0, rows[i].dat});
      idle(3);
      check(hso32, {28'h0, rows[i].out});
    end
    // Generator one slow at half duty, generator two fast at quarter duty.
    wb(1'b1, 4'h2, 32'h80);
    wb(1'b1, 4'h3, 32'h40);
    wb(1'b1, 4'h4, 32'h2);
    wb(1'b1, 4'h0, 32'h2c);
    idle(4);
    hi1 = 0;
    hi2 = 0;
    repeat (1024) begin
      @(posedge ref_clk);
      hi1 += hso[0];
      hi2 += hso[1];
    end
    check(hi1, 32'd512);
    check(hi2, 32'd256);
    // A control write in stop mode is ignored; the code keeps the value set in normal mode.
    mode <= hsp_pkg::HSP_MODE_STOP;
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b0, 4'h0, 32'h0);
    check(rdat, 32'h2c);
    mode <= hsp_pkg::HSP_MODE_RESTART;
    idle(3);
    check(hso32, 32'h0);
    mode <= hsp_pkg::HSP_MODE_FAILSAFE;
    idle(3);
    check(hso32, 32'h0);
    mode <= hsp_pkg::HSP_MODE_NORMAL;
    wb(1'b1, 4'h0, 32'h09);
    idle(3);
    check(hso32, 32'h3);
    sense.over_current <= 4'h1;
    idle(4);
    check(hso32, 32'h3);
    idle(8);
    check(hso32, 32'h2);
    wb(1'b0, 4'h6, 32'h0);
    check(rdat, 32'h1);
    wb(1'b0, 4'h0, 32'h0);
    check(rdat, 32'h08);
    sense.over_current <= 4'h0;
    // Software clears the flag with a write of one; the tripped output stays off.
    wb(1'b1, 4'h6, 32'h1);
    wb(1'b0, 4'h6, 32'h0);
    check(rdat, 32'h0);
    sense.open_load <= 4'h2;
    idle(8);
    wb(1'b0, 4'h7, 32'h0);
    check(rdat, 32'h0);
    idle(10);
    wb(1'b0, 4'h7, 32'h0);
    check(rdat, 32'h2);
    check(hso32, 32'h2);
    sense.open_load <= 4'h0;
    idle(2);
    wb(1'b0, 4'h7, 32'h0);
    check(rdat, 32'h2);
    wb(1'b1, 4'h7, 32'h2);
    wb(1'b0, 4'h7, 32'h0);
    check(rdat, 32'h0);
    // Recovery disabled: codes are wiped when the supply fault ends.
    sense.supply_over <= 1'b1;
    idle(3);
    check(hso32, 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    check(rdat, 32'h1);
    sense.supply_over <= 1'b0;
    idle(3);
    check(hso32, 32'h0);
    wb(1'b0, 4'h0, 32'h0);
    check(rdat, 32'h0);
    wb(1'b1, 4'h5, 32'h1);
    wb(1'b1, 4'h0, 32'h01);
    sense.supply_under <= 1'b1;
    idle(3);
    check(hso32, 32'h0);
    sense.supply_under <= 1'b0;
    idle(3);
    check(hso32, 32'h1);
    // A low clock enable freezes the switch even through a supply fault.
    en <= 1'b0;
    sense.supply_over <= 1'b1;
    idle(3);
    check(hso32, 32'h1);
    en <= 1'b1;
    idle(3);
    check(hso32, 32'h0);
    sense.supply_over <= 1'b0;
    idle(3);
    check(hso32, 32'h1);
    // Sleep keeps the switch on and the over-current shutdown armed.
    mode <= hsp_pkg::HSP_MODE_SLEEP;
    idle(3);
    check(hso32, 32'h1);
    sense.over_current <= 4'h1;
    idle(12);
    check(hso32, 32'h0);
    wb(1'b0, 4'h6, 32'h0);
    check(rdat, 32'h1);
    // A second reset in mid-run brings every register back to its reset value.
    sense.over_current <= 4'h0;
    mode <= hsp_pkg::HSP_MODE_NORMAL;
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check(hso32, 32'h0);
    wb(1'b0, 4'h6, 32'h0);
    check(rdat, 32'h0);
    wb(1'b0, 4'h5, 32'h0);
    check(rdat, 32'h0);
    finish_test();
  end
endmodule
